//--- common/uie_map.svh
// register offsets, field positions, codes and reset values
`ifndef UIE_MAP_SVH
`define UIE_MAP_SVH
`define UIE_A_FC      3'h0
`define UIE_A_FEATURE_CONTROL    3'h1
`define UIE_A_EFR     3'h2
`define UIE_A_IER     3'h1
`define UIE_A_ISR     3'h2
`define UIE_A_LCR     3'h3
`define UIE_A_LSR     3'h5
`define UIE_LCR_ENH   8'hBF
`define UIE_EFR_UNLK  4
`define UIE_RST8      8'h00
`define UIE_C_LS      6'h06
`define UIE_C_TO      6'h0C
`define UIE_C_RX      6'h04
`define UIE_C_TX      6'h02
`define UIE_C_MS      6'h00
`define UIE_C_XO      6'h10
`define UIE_C_PIN     6'h20
`define UIE_C_NONE    6'h01
`endif

//--- common/uie_pkg.sv
// types shared by the interrupt enable and status block
`default_nettype none
package uie_pkg;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uie_bus_type;
  typedef struct packed {
    logic       fifo_en;
    logic [7:0] rx_level;
    logic [7:0] rx_trig;
    logic       rx_push;
    logic [2:0] top_err;
    logic       push_err;
    logic       overrun;
    logic       fifo_err_any;
    logic       rx_timeout;
    logic       rhr_rd;
    logic       thr_wr;
    logic       thr_empty;
    logic       tsr_empty;
    logic       tx_below_trig;
    logic       modem_delta;
    logic       msr_rd;
    logic       pause_match;
    logic       resume_match;
    logic       special_match;
    logic       rts_pin;
    logic       cts_n_pin;
  } uie_ev_type;
endpackage : uie_pkg
`default_nettype wire

//--- hw/uie_core.sv
// interrupt enable, interrupt source and line status logic of one channel
`include "uie_map.svh"
`default_nettype none
module uie_core (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_sys_rst,
  input  wire uie_pkg::uie_bus_type i_bus,
  input  wire uie_pkg::uie_ev_type  i_ev,
  input  wire logic                 i_ready_status_select_n,
  input  wire logic [3:0]           i_rx_rdy_n,
  input  wire logic [3:0]           i_tx_rdy_n,
  output logic [7:0]                o_rdata,
  output logic                      o_irq,
  output logic                      o_sleep_en,
  output logic [7:0]                o_feature_control,
  output logic [7:0]                o_enhanced_feature
);
  import uie_pkg::*;

  logic [7:0] ier_q;
  logic [7:0] lcr_q;
  logic [7:0] feature_control_q;
  logic [7:0] efr_q;
  logic [7:0] chars_q [0:3];
  logic [7:0] isr_q;
  logic [7:0] rdata_q;
  logic       irq_q;
  logic       sleep_q;
  logic       rdy_q;
  logic       ovr_q;
  logic       ls_q;
  logic       to_q;
  logic       tx_q;
  logic       tx_cond_q;
  logic       pause_q;
  logic       spec_q;
  logic       rts_q;
  logic       cts_q;
  logic       rts_f_q;
  logic       cts_f_q;
  logic       enh;
  logic       unlock;
  logic       wr_ier;
  logic       rd_isr;
  logic       rd_lsr;
  logic       tx_cond;
  logic       rx_cond;
  logic [7:0] line_status;
  logic [5:0] code_d;
  logic       any_d;
  logic       s_ls;
  logic       s_to;
  logic       s_rx;
  logic       s_tx;
  logic       s_ms;
  logic       s_xo;
  logic       s_pin;
  logic [7:0] ier_wmask;

  assign enh    = (lcr_q == `UIE_LCR_ENH);
  assign unlock = efr_q[`UIE_EFR_UNLK];
  assign wr_ier = i_bus.wr & ~enh & (i_bus.addr == `UIE_A_IER);
  assign rd_isr = i_bus.rd & ~enh & (i_bus.addr == `UIE_A_ISR) & i_ready_status_select_n;
  assign rd_lsr = i_bus.rd & ~enh & (i_bus.addr == `UIE_A_LSR) & i_ready_status_select_n;

  // upper mask bits only writable while unlocked
  assign ier_wmask = unlock ? 8'hFF : 8'h0F;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ier_q <= `UIE_RST8;
    end else if (wr_ier) begin
      ier_q <= (i_bus.wdata & ier_wmask) | (ier_q & ~ier_wmask);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      lcr_q  <= `UIE_RST8;
      feature_control_q <= `UIE_RST8;
      efr_q  <= `UIE_RST8;
    end else if (i_bus.wr) begin
      if (i_bus.addr == `UIE_A_LCR) begin
        lcr_q <= i_bus.wdata;
      end else if (enh && i_bus.addr == `UIE_A_FEATURE_CONTROL) begin
        feature_control_q <= i_bus.wdata;
      end else if (enh && i_bus.addr == `UIE_A_EFR) begin
        efr_q <= i_bus.wdata;
      end
    end
  end

  generate
    for (genvar gi = 0; gi < 4; gi++) begin : g_char
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          chars_q[gi] <= `UIE_RST8;
        end else if (i_bus.wr && enh && i_bus.addr == {1'b1, 2'(gi)}) begin
          chars_q[gi] <= i_bus.wdata;
        end
      end
    end
  endgenerate

  // data ready: set on push wins over empty
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rdy_q <= 1'b0;
    end else if (i_ev.rx_push) begin
      rdy_q <= 1'b1;
    end else if (i_ev.rx_level == 8'h00) begin
      rdy_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ovr_q <= 1'b0;
    end else if (i_ev.overrun) begin
      ovr_q <= 1'b1;
    end else if (rd_lsr) begin
      ovr_q <= 1'b0;
    end
  end

  // line status pending on errored push or overrun
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ls_q <= 1'b0;
    end else if ((i_ev.rx_push && i_ev.push_err) || i_ev.overrun) begin
      ls_q <= 1'b1;
    end else if (rd_lsr) begin
      ls_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      to_q <= 1'b0;
    end else if (i_ev.rx_timeout) begin
      to_q <= 1'b1;
    end else if (i_ev.rhr_rd) begin
      to_q <= 1'b0;
    end
  end

  assign tx_cond = i_ev.fifo_en ? i_ev.tx_below_trig : i_ev.thr_empty;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tx_cond_q <= 1'b0;
      tx_q      <= 1'b0;
    end else begin
      tx_cond_q <= tx_cond;
      if ((tx_cond && !tx_cond_q) || (wr_ier && i_bus.wdata[1] && !ier_q[1] && tx_cond)) begin
        tx_q <= 1'b1;
      end else if (i_ev.thr_wr || (rd_isr && isr_q[5:0] == `UIE_C_TX)) begin
        tx_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pause_q <= 1'b0;
      spec_q  <= 1'b0;
    end else begin
      if (i_ev.pause_match) begin
        pause_q <= 1'b1;
      end else if (i_ev.resume_match || (rd_isr && isr_q[5:0] == `UIE_C_XO)) begin
        pause_q <= 1'b0;
      end
      if (i_ev.special_match) begin
        spec_q <= 1'b1;
      end else if (i_ev.rx_push || (rd_isr && isr_q[5:0] == `UIE_C_XO)) begin
        spec_q <= 1'b0;
      end
    end
  end

  // low to high edges on the flow pins
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rts_q   <= 1'b0;
      cts_q   <= 1'b0;
      rts_f_q <= 1'b0;
      cts_f_q <= 1'b0;
    end else begin
      rts_q <= i_ev.rts_pin;
      cts_q <= i_ev.cts_n_pin;
      if (i_ev.rts_pin && !rts_q) begin
        rts_f_q <= 1'b1;
      end else if (i_ev.msr_rd) begin
        rts_f_q <= 1'b0;
      end
      if (i_ev.cts_n_pin && !cts_q) begin
        cts_f_q <= 1'b1;
      end else if (i_ev.msr_rd) begin
        cts_f_q <= 1'b0;
      end
    end
  end

  // fifo mode follows trigger level, else a held character
  assign rx_cond = i_ev.fifo_en ? (i_ev.rx_level >= i_ev.rx_trig) : rdy_q;

  // all enables off leaves the host polling line status
  assign s_ls  = ier_q[2] & ls_q;
  assign s_to  = ier_q[0] & to_q;
  assign s_rx  = ier_q[0] & rx_cond;
  assign s_tx  = ier_q[1] & tx_q;
  assign s_ms  = ier_q[3] & i_ev.modem_delta;
  assign s_xo  = unlock & ier_q[5] & (pause_q | spec_q);
  assign s_pin = unlock & ((ier_q[6] & rts_f_q) | (ier_q[7] & cts_f_q));

  always_comb begin
    any_d  = 1'b1;
    if (s_ls) begin
      code_d = `UIE_C_LS;
    end else if (s_to) begin
      code_d = `UIE_C_TO;
    end else if (s_rx) begin
      code_d = `UIE_C_RX;
    end else if (s_tx) begin
      code_d = `UIE_C_TX;
    end else if (s_ms) begin
      code_d = `UIE_C_MS;
    end else if (s_xo) begin
      code_d = `UIE_C_XO;
    end else if (s_pin) begin
      code_d = `UIE_C_PIN;
    end else begin
      code_d = `UIE_C_NONE;
      any_d  = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      isr_q   <= {2'b00, `UIE_C_NONE};
      irq_q   <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      isr_q   <= {i_ev.fifo_en, i_ev.fifo_en, code_d};
      irq_q   <= any_d;
      sleep_q <= ier_q[4] & unlock;
    end
  end

  assign line_status = {i_ev.fifo_err_any,
                i_ev.thr_empty & i_ev.tsr_empty,
                i_ev.thr_empty,
                i_ev.top_err,
                ovr_q,
                rdy_q};

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rdata_q <= `UIE_RST8;
    end else if (i_bus.rd) begin
      if (!i_ready_status_select_n) begin
        rdata_q <= {i_rx_rdy_n, i_tx_rdy_n};
      end else if (i_bus.addr == `UIE_A_LCR) begin
        rdata_q <= lcr_q;
      end else if (enh) begin
        case (i_bus.addr)
          `UIE_A_FC:   rdata_q <= i_ev.rx_level;
          `UIE_A_FEATURE_CONTROL: rdata_q <= feature_control_q;
          `UIE_A_EFR:  rdata_q <= efr_q;
          3'h4, 3'h5, 3'h6, 3'h7: rdata_q <= chars_q[i_bus.addr[1:0]];
          default:     rdata_q <= `UIE_RST8;
        endcase
      end else begin
        case (i_bus.addr)
          `UIE_A_IER: rdata_q <= ier_q;
          `UIE_A_ISR: rdata_q <= isr_q;
          `UIE_A_LSR: rdata_q <= line_status;
          default:    rdata_q <= `UIE_RST8;
        endcase
      end
    end
  end

  assign o_rdata            = rdata_q;
  assign o_irq              = irq_q;
  assign o_sleep_en         = sleep_q;
  assign o_feature_control  = feature_control_q;
  assign o_enhanced_feature = efr_q;

endmodule : uie_core
`default_nettype wire

//--- verif/uie_host.sv
// host model that drives the block's parallel register bus
`default_nettype none
module uie_host (
  input  wire logic                 i_core_clk,
  input  wire logic [7:0]           i_rdata,
  output var  uie_pkg::uie_bus_type o_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  import uie_pkg::*;
  initial o_bus = '0;
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge i_core_clk);
    o_bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge i_core_clk);
    o_bus.rd <= 1'b0;
    // read data stands until the next read strobe
    @(posedge i_core_clk);
    d = i_rdata;
  endtask : rd
endmodule : uie_host
`default_nettype wire

//--- verif/uie_core_chk.sv
// assertions on the ports of the interrupt enable and status block
`default_nettype none
module uie_core_chk (
  input wire logic                 i_core_clk,
  input wire logic                 i_sys_rst,
  input wire uie_pkg::uie_bus_type i_bus,
  input wire uie_pkg::uie_ev_type  i_ev,
  input wire logic                 i_ready_status_select_n,
  input wire logic [3:0]           i_rx_rdy_n,
  input wire logic [3:0]           i_tx_rdy_n,
  input wire logic [7:0]           o_rdata,
  input wire logic                 o_irq,
  input wire logic                 o_sleep_en,
  input wire logic [7:0]           o_feature_control,
  input wire logic [7:0]           o_enhanced_feature
);
  import uie_pkg::*;
  logic [7:0] lcr_q;
  wire logic  enh = lcr_q == 8'hBF;
  wire logic  nrd = i_bus.rd && i_ready_status_select_n && !enh;
  // mirror of line_control for bank selection
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) lcr_q <= 8'h00;
    else if (i_bus.wr && i_bus.addr == 3'h3) lcr_q <= i_bus.wdata;
  end
  default clocking dc @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  AST_RST: assert property (disable iff (1'b0)
    i_sys_rst |=> !o_irq && !o_sleep_en && o_rdata == 8'h00) else $error("reset values");
  AST_HOLD: assert property (!$past(i_bus.rd) |-> $stable(o_rdata)) else $error("rdata moved");
  AST_PINS: assert property (i_bus.rd && !i_ready_status_select_n
    |=> o_rdata == $past({i_rx_rdy_n, i_tx_rdy_n})) else $error("pin status");
  AST_LS: assert property (nrd && i_bus.addr == 3'h5 |=> o_rdata[7:2] == $past(
    {i_ev.fifo_err_any, i_ev.thr_empty & i_ev.tsr_empty, i_ev.thr_empty, i_ev.top_err}))
    else $error("line status");
  AST_SRC: assert property (nrd && i_bus.addr == 3'h2 && $stable(i_ev.fifo_en)
    |=> o_rdata[7:6] == {2{$past(i_ev.fifo_en)}} && o_rdata[0] == !$past(o_irq)
    && o_rdata[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
    else $error("source code");
  AST_SLEEP: assert property (!o_enhanced_feature[4] && !$past(o_enhanced_feature[4])
    |-> !o_sleep_en) else $error("sleep unlocked");
  AST_EFR: assert property (i_bus.wr && enh && i_bus.addr == 3'h2
    |=> o_enhanced_feature == $past(i_bus.wdata)) else $error("feature write");
  AST_LOCK: assert property (i_bus.wr && !enh
    |=> $stable(o_enhanced_feature) && $stable(o_feature_control)) else $error("bank leak");
endmodule : uie_core_chk
bind uie_core uie_core_chk uie_core_chk_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_bus(i_bus), .i_ev(i_ev), .i_ready_status_select_n(i_ready_status_select_n),
  .i_rx_rdy_n(i_rx_rdy_n), .i_tx_rdy_n(i_tx_rdy_n), .o_rdata(o_rdata), .o_irq(o_irq),
  .o_sleep_en(o_sleep_en), .o_feature_control(o_feature_control),
  .o_enhanced_feature(o_enhanced_feature));
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the interrupt enable and status block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import uie_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, sel_n = 1'b1, irq, slp;
  uie_bus_type bus;
  uie_ev_type  ev = '{thr_empty: 1'b1, tsr_empty: 1'b1, default: '0};
  logic [7:0]  rdata, feature_control, enhanced_feature;
  int          fails = 0, n_checks = 0;
  always #2 clk = ~clk;
  uie_core uie_core_i (.i_core_clk(clk), .i_sys_rst(rst), .i_bus(bus), .i_ev(ev),
    .i_ready_status_select_n(sel_n), .i_rx_rdy_n(4'hA), .i_tx_rdy_n(4'h5), .o_rdata(rdata),
    .o_irq(irq), .o_sleep_en(slp), .o_feature_control(feature_control), .o_enhanced_feature(enhanced_feature));
  uie_host uie_host_i (.i_core_clk(clk), .i_rdata(rdata), .o_bus(bus));
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask : cy
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ck
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cy(3);
    uie_host_i.rd(a, d);
    ck(d, exp);
  endtask : rd
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    uie_host_i.wr(a, d);
  endtask : wr
  // one-cycle event pulse on top of the present levels
  task automatic go(input uie_ev_type p);
    @(posedge clk) ev <= uie_ev_type'(ev | p);
    @(posedge clk) ev <= uie_ev_type'(ev & ~p);
  endtask : go
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    cy(5000);
    fails++;
    $display("wrong value at %0t: run did not finish", $time);
    close_out();
  end
  initial begin
    cy(20);
    rst <= 1'b0;
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h01);
    rd(3'h5, 8'h60);
    @(posedge clk) ev.tsr_empty <= 1'b0;
    rd(3'h5, 8'h20);
    wr(3'h1, 8'h02);
    cy(3);
    ck({7'h00, irq}, 8'h01);
    rd(3'h2, 8'h02);
    rd(3'h2, 8'h01);
    @(posedge clk) ev.thr_empty <= 1'b0;
    @(posedge clk) ev.thr_empty <= 1'b1;
    cy(3);
    ck({7'h00, irq}, 8'h01);
    go('{thr_wr: 1'b1, default: '0});
    rd(3'h2, 8'h01);
    wr(3'h1, 8'h07);
    @(posedge clk) ev.rx_level <= 8'h01;
    go('{rx_push: 1'b1, default: '0});
    rd(3'h2, 8'h04);
    rd(3'h5, 8'h21);
    @(posedge clk) ev.top_err <= 3'h2;
    go('{rx_push: 1'b1, push_err: 1'b1, default: '0});
    rd(3'h2, 8'h06);
    rd(3'h5, 8'h29);
    rd(3'h2, 8'h04);
    @(posedge clk) ev.fifo_err_any <= 1'b1;
    go('{overrun: 1'b1, default: '0});
    rd(3'h5, 8'hAB);
    @(posedge clk) ev <= '{thr_empty: 1'b1, default: '0};
    rd(3'h2, 8'h01);
    rd(3'h5, 8'h20);
    @(posedge clk) ev <= '{fifo_en: 1'b1, rx_trig: 8'h04, rx_level: 8'h04,
                           thr_empty: 1'b1, default: '0};
    rd(3'h2, 8'hC4);
    @(posedge clk) ev.rx_level <= 8'h03;
    rd(3'h2, 8'hC1);
    go('{rx_timeout: 1'b1, default: '0});
    rd(3'h2, 8'hCC);
    go('{rhr_rd: 1'b1, default: '0});
    rd(3'h2, 8'hC1);
    wr(3'h1, 8'h00);
    go('{overrun: 1'b1, default: '0});
    cy(3);
    ck({7'h00, irq}, 8'h00);
    rd(3'h5, 8'h22);
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'h10);
    wr(3'h1, 8'h5A);
    rd(3'h1, 8'h5A);
    ck(feature_control, 8'h5A);
    ck(enhanced_feature, 8'h10);
    wr(3'h6, 8'h13);
    rd(3'h6, 8'h13);
    rd(3'h0, 8'h03);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'hF0);
    rd(3'h1, 8'hF0);
    ck({7'h00, slp}, 8'h01);
    @(posedge clk) ev.rts_pin <= 1'b1;
    rd(3'h2, 8'hE0);
    go('{msr_rd: 1'b1, default: '0});
    @(posedge clk) ev.cts_n_pin <= 1'b1;
    rd(3'h2, 8'hE0);
    go('{msr_rd: 1'b1, pause_match: 1'b1, default: '0});
    rd(3'h2, 8'hD0);
    rd(3'h2, 8'hC1);
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h00);
    rd(3'h1, 8'hF0);
    ck({7'h00, slp}, 8'h00);
    @(posedge clk) sel_n <= 1'b0;
    rd(3'h7, 8'hA5);
    @(posedge clk) sel_n <= 1'b1;
    @(posedge clk) rst <= 1'b1;
    cy(3);
    rst <= 1'b0;
    rd(3'h1, 8'h00);
    rd(3'h2, 8'hC1);
    ck(feature_control, 8'h00);
    ck(enhanced_feature, 8'h00);
    close_out();
  end
endmodule : testbench
`default_nettype wire
